// ===== hdl/status_defines.vh
/*
  Command codes, bit positions, valid-bit masks and reset values of the status register groups.
  Included by the top design file, the property file and the bench (not the host model); holds definitions only.
*/
`ifndef STATUS_DEFINES_VH
`define STATUS_DEFINES_VH

// command codes on cmd_code_i
`define CMD_CLEAR_STATUS        5'h01
`define CMD_STATUS_PRESET       5'h02
`define CMD_EVENT_MASK_WRITE    5'h03
`define CMD_QUALITY_MASK_WRITE  5'h04
`define CMD_ALARM_MASK_WRITE    5'h05
`define CMD_OPER_MASK_WRITE     5'h06
`define CMD_POWER_ON_CLEAR_WR   5'h07
`define CMD_COMPLETION_MARKER   5'h08
`define CMD_THRESHOLD_WRITE     5'h09
`define CMD_EVENT_LATCH_READ    5'h10
`define CMD_QUALITY_LATCH_READ  5'h11
`define CMD_ALARM_LATCH_READ    5'h12
`define CMD_OPER_LATCH_READ     5'h13
`define CMD_EVENT_MASK_READ     5'h14
`define CMD_QUALITY_MASK_READ   5'h15
`define CMD_ALARM_MASK_READ     5'h16
`define CMD_OPER_MASK_READ      5'h17
`define CMD_ALARM_COND_READ     5'h18
`define CMD_OPER_COND_READ      5'h19
`define CMD_POWER_ON_CLEAR_RD   5'h1A
`define CMD_THRESHOLD_READ      5'h1B

// standard event bits
`define EV_OPC_BIT              0
`define EV_QUERY_BIT            2
`define EV_DEVICE_BIT           3
`define EV_EXEC_BIT             4
`define EV_SYNTAX_BIT           5
`define EV_POWER_BIT            7
`define EV_VALID                8'hBD

// quality bits
`define QU_VOLT_BIT             0
`define QU_CURR_BIT             1
`define QU_RES_BIT              9
`define QU_TEMP_BIT             10
`define QU_TOTAL_BIT            11
`define QU_MEM_BIT              12
`define QU_VALID                16'h1E03

// alarm bits
`define AL_QUEUE_BIT            4
`define AL_OVERFLOW_BIT         5
`define AL_VALID                16'h003F

// operation bits
`define OP_SCAN_BIT             4
`define OP_CONFIG_BIT           8
`define OP_THRESH_BIT           9
`define OP_VALID                16'h0310

// status byte summary positions
`define SB_QUALITY_BIT          3
`define SB_EVENT_BIT            5
`define SB_OPER_BIT             7

// reset values
`define THRESHOLD_RESET         16'h0001
`define MASK_RESET              16'h0000

`endif

// ===== hdl/pin_sync.v
/*
  Three-stage synchroniser for pins; a change counts once the second and third stages agree.
  Assumes inputs asynchronous to core_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : bit_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg level_q;
      always @(posedge core_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          s1_q    <= 1'b0;
          s2_q    <= 1'b0;
          s3_q    <= 1'b0;
          level_q <= 1'b0;
        end
        else
        begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
          begin
            level_q <= s3_q;
          end
        end
      end
      assign level_o[g] = level_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== hdl/status_group.v
/*
  One status register group: sticky event latch, enable mask and registered summary.
  Assumes set, clear and mask strobes come from logic on core_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module status_group #(
  parameter             WIDTH = 16,
  parameter [WIDTH-1:0] VALID = {WIDTH{1'b1}}
) (
  input  wire             core_clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] set_i,
  input  wire             clr_i,
  input  wire             mask_wr_i,
  input  wire             mask_clr_i,
  input  wire [WIDTH-1:0] mask_i,
  output reg  [WIDTH-1:0] latch_o,
  output reg  [WIDTH-1:0] mask_o,
  output reg              summary_o
);

  reg [WIDTH-1:0] latch_d;
  reg [WIDTH-1:0] mask_d;

  always @*
  begin
    // a set in the clearing cycle survives
    latch_d = ({WIDTH{~clr_i}} & latch_o) | (set_i & VALID);
    mask_d  = mask_o;
    if (mask_clr_i)
    begin
      mask_d = {WIDTH{1'b0}};
    end
    else if (mask_wr_i)
    begin
      mask_d = mask_i & VALID;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      latch_o   <= {WIDTH{1'b0}};
      mask_o    <= {WIDTH{1'b0}};
      summary_o <= 1'b0;
    end
    else
    begin
      latch_o   <= latch_d;
      mask_o    <= mask_d;
      summary_o <= |(latch_d & mask_d);
    end
  end

endmodule

`default_nettype wire

// ===== hdl/status_event_register_groups.v
/*
  Status reporting groups: quality, standard event, alarm and operation latches with masks,
  a command port for writes and queries, and summaries for the status byte.
  Assumes event inputs are on core_clk_i except the front-panel change pin, and that
  nonvolatile power-on-clear flag and event mask are presented on nv_* from reset release.
*/
`timescale 1ns/100ps
`default_nettype none
`include "status_defines.vh"

module status_event_register_groups (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  input  wire        cmd_valid_i,
  input  wire [4:0]  cmd_code_i,
  input  wire [15:0] cmd_data_i,
  output reg         cmd_ready_o,
  output reg         resp_valid_o,
  output reg  [15:0] resp_data_o,
  input  wire        nv_power_on_clear_i,
  input  wire [7:0]  nv_event_mask_i,
  output reg         power_on_clear_o,
  output wire [7:0]  event_mask_o,
  input  wire        commands_idle_i,
  input  wire        read_empty_err_i,
  input  wire        unread_query_err_i,
  input  wire        buffers_full_err_i,
  input  wire        selftest_err_i,
  input  wire        exec_err_i,
  input  wire        syntax_err_i,
  input  wire [3:0]  overload_i,
  input  wire        totalizer_overflow_i,
  input  wire        memory_overflow_i,
  input  wire [3:0]  alarm_hit_i,
  input  wire        alarm_queue_busy_i,
  input  wire        alarm_queue_overflow_i,
  input  wire        scanning_i,
  input  wire        scan_start_i,
  input  wire        front_panel_change_i,
  input  wire [15:0] readings_stored_i,
  output reg  [7:0]  status_byte_o,
  output reg         alarm_summary_o,
  output reg         err_push_o,
  output reg  [3:0]  err_bits_o
);

  localparam [1:0] ST_CAPTURE = 2'b01;
  localparam [1:0] ST_RUN     = 2'b10;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         opc_armed_q;
  reg  [15:0] threshold_q;
  reg         thresh_reached_q;
  reg         config_cond_q;
  reg         panel_level_q;
  reg  [15:0] alarm_cond_q;
  reg  [15:0] oper_cond_q;

  wire        panel_level;
  wire        run;
  wire        cmd;
  wire [7:0]  ev_latch;
  wire [15:0] qu_latch;
  wire [15:0] qu_mask;
  wire [15:0] al_latch;
  wire [15:0] al_mask;
  wire [15:0] op_latch;
  wire [15:0] op_mask;
  wire        ev_sum;
  wire        qu_sum;
  wire        al_sum;
  wire        op_sum;

  reg  [7:0]  ev_set;
  reg  [15:0] qu_set;
  reg  [15:0] al_set;
  reg  [15:0] op_set;
  reg  [15:0] alarm_cond_d;
  reg  [15:0] oper_cond_d;
  reg         is_clear;
  reg         is_preset;
  reg         known;
  reg         thresh_now;
  reg  [3:0]  err_d;
  reg         resp_d;
  reg  [15:0] resp_data_d;

  assign run = (state_q == ST_RUN);
  assign cmd = run & cmd_valid_i;

  pin_sync #(
    .WIDTH (1)
  ) u_panel_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .pin_i      (front_panel_change_i),
    .level_o    (panel_level)
  );

  // power-up sequencing
  always @*
  begin
    case (state_q)
      ST_CAPTURE:
      begin
        state_d = ST_RUN;
      end
      ST_RUN:
      begin
        state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_CAPTURE;
      end
    endcase
  end

  // command decode
  always @*
  begin
    is_clear  = cmd & (cmd_code_i == `CMD_CLEAR_STATUS);
    is_preset = cmd & (cmd_code_i == `CMD_STATUS_PRESET);
    known     = 1'b1;
    resp_d    = 1'b0;
    resp_data_d = 16'h0000;
    if (cmd)
    begin
      case (cmd_code_i)
        `CMD_CLEAR_STATUS,
        `CMD_STATUS_PRESET,
        `CMD_EVENT_MASK_WRITE,
        `CMD_QUALITY_MASK_WRITE,
        `CMD_ALARM_MASK_WRITE,
        `CMD_OPER_MASK_WRITE,
        `CMD_POWER_ON_CLEAR_WR,
        `CMD_COMPLETION_MARKER,
        `CMD_THRESHOLD_WRITE:
        begin
          known = 1'b1;
        end
        `CMD_EVENT_LATCH_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = {8'h00, ev_latch};
        end
        `CMD_QUALITY_LATCH_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = qu_latch;
        end
        `CMD_ALARM_LATCH_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = al_latch;
        end
        `CMD_OPER_LATCH_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = op_latch;
        end
        `CMD_EVENT_MASK_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = {8'h00, event_mask_o};
        end
        `CMD_QUALITY_MASK_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = qu_mask;
        end
        `CMD_ALARM_MASK_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = al_mask;
        end
        `CMD_OPER_MASK_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = op_mask;
        end
        `CMD_ALARM_COND_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = alarm_cond_q;
        end
        `CMD_OPER_COND_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = oper_cond_q;
        end
        `CMD_POWER_ON_CLEAR_RD:
        begin
          resp_d      = 1'b1;
          resp_data_d = {15'h0000, power_on_clear_o};
        end
        `CMD_THRESHOLD_READ:
        begin
          resp_d      = 1'b1;
          resp_data_d = threshold_q;
        end
        default:
        begin
          known = 1'b0;
        end
      endcase
    end
  end

  // event sources
  always @*
  begin
    thresh_now = (readings_stored_i >= threshold_q);
    alarm_cond_d = 16'h0000;
    alarm_cond_d[`AL_QUEUE_BIT] = alarm_queue_busy_i;
    oper_cond_d = 16'h0000;
    oper_cond_d[`OP_SCAN_BIT]   = scanning_i;
    oper_cond_d[`OP_CONFIG_BIT] = config_cond_q;
    oper_cond_d[`OP_THRESH_BIT] = thresh_reached_q;

    ev_set = 8'h00;
    ev_set[`EV_OPC_BIT]    = opc_armed_q & commands_idle_i;
    ev_set[`EV_QUERY_BIT]  = read_empty_err_i | unread_query_err_i | buffers_full_err_i;
    ev_set[`EV_DEVICE_BIT] = selftest_err_i | (|overload_i);
    ev_set[`EV_EXEC_BIT]   = exec_err_i;
    ev_set[`EV_SYNTAX_BIT] = syntax_err_i | (cmd & ~known);
    ev_set[`EV_POWER_BIT]  = (state_q == ST_CAPTURE);

    // overload alone leaves the error queue alone
    err_d = {ev_set[`EV_SYNTAX_BIT], ev_set[`EV_EXEC_BIT], selftest_err_i, ev_set[`EV_QUERY_BIT]};

    qu_set = 16'h0000;
    qu_set[`QU_VOLT_BIT]  = overload_i[0];
    qu_set[`QU_CURR_BIT]  = overload_i[1];
    qu_set[`QU_RES_BIT]   = overload_i[2];
    qu_set[`QU_TEMP_BIT]  = overload_i[3];
    qu_set[`QU_TOTAL_BIT] = totalizer_overflow_i;
    qu_set[`QU_MEM_BIT]   = memory_overflow_i;

    al_set = 16'h0000;
    al_set[3:0] = alarm_hit_i;
    al_set[`AL_QUEUE_BIT]    = alarm_queue_busy_i & ~alarm_cond_q[`AL_QUEUE_BIT];
    al_set[`AL_OVERFLOW_BIT] = alarm_queue_overflow_i;

    // rising condition edges latch into the operation group
    op_set = oper_cond_d & ~oper_cond_q;
  end

  status_group #(
    .WIDTH (8),
    .VALID (`EV_VALID)
  ) u_event (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (ev_set),
    .clr_i      (is_clear | (cmd & (cmd_code_i == `CMD_EVENT_LATCH_READ))),
    .mask_wr_i  ((state_q == ST_CAPTURE) | (cmd & (cmd_code_i == `CMD_EVENT_MASK_WRITE))),
    .mask_clr_i ((state_q == ST_CAPTURE) & nv_power_on_clear_i),
    .mask_i     (run ? cmd_data_i[7:0] : nv_event_mask_i),
    .latch_o    (ev_latch),
    .mask_o     (event_mask_o),
    .summary_o  (ev_sum)
  );

  status_group #(
    .WIDTH (16),
    .VALID (`QU_VALID)
  ) u_quality (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (qu_set),
    .clr_i      (is_clear | (cmd & (cmd_code_i == `CMD_QUALITY_LATCH_READ))),
    .mask_wr_i  (cmd & (cmd_code_i == `CMD_QUALITY_MASK_WRITE)),
    .mask_clr_i (is_preset),
    .mask_i     (cmd_data_i),
    .latch_o    (qu_latch),
    .mask_o     (qu_mask),
    .summary_o  (qu_sum)
  );

  status_group #(
    .WIDTH (16),
    .VALID (`AL_VALID)
  ) u_alarm (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (al_set),
    .clr_i      (is_clear | (cmd & (cmd_code_i == `CMD_ALARM_LATCH_READ))),
    .mask_wr_i  (cmd & (cmd_code_i == `CMD_ALARM_MASK_WRITE)),
    .mask_clr_i (is_preset),
    .mask_i     (cmd_data_i),
    .latch_o    (al_latch),
    .mask_o     (al_mask),
    .summary_o  (al_sum)
  );

  status_group #(
    .WIDTH (16),
    .VALID (`OP_VALID)
  ) u_oper (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (op_set),
    .clr_i      (is_clear | (cmd & (cmd_code_i == `CMD_OPER_LATCH_READ))),
    .mask_wr_i  (cmd & (cmd_code_i == `CMD_OPER_MASK_WRITE)),
    .mask_clr_i (is_preset),
    .mask_i     (cmd_data_i),
    .latch_o    (op_latch),
    .mask_o     (op_mask),
    .summary_o  (op_sum)
  );

  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q          <= ST_CAPTURE;
      power_on_clear_o <= 1'b0;
      opc_armed_q      <= 1'b0;
      threshold_q      <= `THRESHOLD_RESET;
      thresh_reached_q <= 1'b0;
      config_cond_q    <= 1'b0;
      panel_level_q    <= 1'b0;
      alarm_cond_q     <= 16'h0000;
      oper_cond_q      <= 16'h0000;
      cmd_ready_o      <= 1'b0;
      resp_valid_o     <= 1'b0;
      resp_data_o      <= 16'h0000;
      status_byte_o    <= 8'h00;
      alarm_summary_o  <= 1'b0;
      err_push_o       <= 1'b0;
      err_bits_o       <= 4'h0;
    end
    else
    begin
      state_q     <= state_d;
      cmd_ready_o <= (state_d == ST_RUN);
      if (state_q == ST_CAPTURE)
      begin
        power_on_clear_o <= nv_power_on_clear_i;
      end
      else if (cmd & (cmd_code_i == `CMD_POWER_ON_CLEAR_WR))
      begin
        power_on_clear_o <= cmd_data_i[0];
      end
      if (cmd & (cmd_code_i == `CMD_COMPLETION_MARKER))
      begin
        opc_armed_q <= 1'b1;
      end
      else if (commands_idle_i | is_clear)
      begin
        opc_armed_q <= 1'b0;
      end
      if (cmd & (cmd_code_i == `CMD_THRESHOLD_WRITE))
      begin
        threshold_q <= (cmd_data_i == 16'h0000) ? `THRESHOLD_RESET : cmd_data_i;
      end
      // rearms only after the count drops below the threshold
      thresh_reached_q <= thresh_now;
      panel_level_q    <= panel_level;
      if (scan_start_i)
      begin
        config_cond_q <= 1'b0;
      end
      else if (panel_level & ~panel_level_q)
      begin
        config_cond_q <= 1'b1;
      end
      alarm_cond_q    <= alarm_cond_d;
      oper_cond_q     <= oper_cond_d;
      resp_valid_o    <= resp_d;
      resp_data_o     <= resp_data_d;
      status_byte_o   <= {op_sum, 1'b0, ev_sum, 1'b0, qu_sum, 3'b000};
      alarm_summary_o <= al_sum;
      err_push_o      <= |err_d;
      err_bits_o      <= err_d;
    end
  end

endmodule

`default_nettype wire

// ===== test/host_model.sv
/*
  Host side of the command port: issues one command, then gathers any answer.
  Assumes the caller starts each command just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input  wire logic        core_clk_i,
  input  wire logic        cmd_ready_i,
  input  wire logic        resp_valid_i,
  input  wire logic [15:0] resp_data_i,
  output var  logic        cmd_valid_o,
  output var  logic [4:0]  cmd_code_o,
  output var  logic [15:0] cmd_data_o
);
  logic [15:0] resp;
  logic        got;

  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 5'h00;
    cmd_data_o  = 16'h0000;
  end

  // mask values are binary-weighted sums
  task automatic send(input logic [4:0] c, input logic [15:0] d);
    cmd_valid_o <= 1'b1;
    cmd_code_o  <= c;
    cmd_data_o  <= d;
    do @(posedge core_clk_i); while (cmd_ready_i !== 1'b1);
    cmd_valid_o <= 1'b0;
    cmd_data_o  <= ~d;
    @(posedge core_clk_i);
    got  = resp_valid_i;
    resp = resp_data_i;
    #1;
  endtask
endmodule

`default_nettype wire

// ===== test/status_event_register_groups_properties.sv
/*
  Port-level assertions for the status register groups.
  Assumes binding to the top module, single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "status_defines.vh"

module status_props (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        cmd_valid_i,
  input wire logic [4:0]  cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic        cmd_ready_o,
  input wire logic        resp_valid_o,
  input wire logic [7:0]  event_mask_o,
  input wire logic        commands_idle_i,
  input wire logic        read_empty_err_i,
  input wire logic        unread_query_err_i,
  input wire logic        buffers_full_err_i,
  input wire logic        selftest_err_i,
  input wire logic        exec_err_i,
  input wire logic        syntax_err_i,
  input wire logic [3:0]  overload_i,
  input wire logic        totalizer_overflow_i,
  input wire logic        memory_overflow_i,
  input wire logic [7:0]  status_byte_o,
  input wire logic        err_push_o,
  input wire logic [3:0]  err_bits_o
);
  wire logic qerr = read_empty_err_i | unread_query_err_i | buffers_full_err_i;
  wire logic errq = qerr | selftest_err_i | exec_err_i | syntax_err_i;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_cmd(logic [4:0] c);
    cmd_valid_i && cmd_ready_o && cmd_code_i == c;
  endsequence

  AST_EXEC_PUSH: assert property (exec_err_i && cmd_ready_o |=> err_push_o && err_bits_o[2])
    else $error("execution error not pushed");
  AST_SELF_PUSH: assert property (selftest_err_i && cmd_ready_o |=> err_push_o && err_bits_o[1])
    else $error("self-test error not pushed");
  AST_QUERY_PUSH: assert property (qerr && cmd_ready_o |=> err_push_o && err_bits_o[0])
    else $error("query error not pushed");
  AST_SYNTAX_PUSH: assert property (syntax_err_i && cmd_ready_o |=> err_push_o && err_bits_o[3])
    else $error("syntax error not pushed");
  AST_OVL_NOPUSH: assert property (overload_i != 4'h0 && !errq && !cmd_valid_i |=> !err_push_o)
    else $error("overload pushed an error");
  AST_EXEC_SUM: assert property (exec_err_i && cmd_ready_o && event_mask_o[4] && !cmd_valid_i
    |=> ##1 status_byte_o[5])
    else $error("event summary missing");
  AST_EV_READ_CLR: assert property (s_cmd(`CMD_EVENT_LATCH_READ) ##0 (!errq && overload_i == 4'h0 && !commands_idle_i)
    |=> resp_valid_o ##1 !status_byte_o[5])
    else $error("event latch not cleared by read");
  AST_QU_READ_CLR: assert property (s_cmd(`CMD_QUALITY_LATCH_READ)
    ##0 (overload_i == 4'h0 && !totalizer_overflow_i && !memory_overflow_i)
    |=> resp_valid_o ##1 !status_byte_o[3])
    else $error("quality latch not cleared by read");
  AST_MASK_WR: assert property (s_cmd(`CMD_EVENT_MASK_WRITE)
    |=> {8'h00, event_mask_o} == ($past(cmd_data_i) & 16'h00BD))
    else $error("event mask write wrong");
  AST_SB_UNUSED: assert property ((status_byte_o & 8'h57) == 8'h00)
    else $error("unused status byte bit set");
endmodule

`default_nettype wire

// ===== test/status_event_register_groups_tb.sv
/*
  Self-checking bench for the status register groups, random events plus corner cases.
  Assumes the host model drives the command port.
*/
`timescale 1ns/100ps
`default_nettype none
`include "status_defines.vh"

module status_event_register_groups_tb;
  logic core_clk_i, rst_b_i, cmd_valid_i, cmd_ready_o, resp_valid_o, nv_power_on_clear_i, power_on_clear_o;
  logic commands_idle_i, alarm_queue_busy_i, scanning_i, scan_start_i, front_panel_change_i;
  logic alarm_summary_o, err_push_o, push;
  logic [4:0]  cmd_code_i;
  logic [15:0] cmd_data_i, resp_data_o, readings_stored_i;
  logic [7:0]  nv_event_mask_i, event_mask_o, status_byte_o, m;
  logic [3:0]  err_bits_o, bits;
  logic [16:0] pv, v;
  logic [15:0] qm;
  wire logic syntax_err_i, exec_err_i, selftest_err_i, buffers_full_err_i, unread_query_err_i;
  wire logic read_empty_err_i, totalizer_overflow_i, memory_overflow_i, alarm_queue_overflow_i;
  wire logic [3:0] overload_i, alarm_hit_i;
  int n_mismatch, cmp_count;

  assign {syntax_err_i, exec_err_i, selftest_err_i, buffers_full_err_i, unread_query_err_i, read_empty_err_i,
          overload_i, totalizer_overflow_i, memory_overflow_i, alarm_hit_i, alarm_queue_overflow_i} = pv;

  status_event_register_groups status_event_register_groups_inst (.core_clk_i, .rst_b_i, .cmd_valid_i,
    .cmd_code_i, .cmd_data_i, .cmd_ready_o, .resp_valid_o, .resp_data_o, .nv_power_on_clear_i, .nv_event_mask_i,
    .power_on_clear_o, .event_mask_o, .commands_idle_i, .read_empty_err_i, .unread_query_err_i,
    .buffers_full_err_i, .selftest_err_i, .exec_err_i, .syntax_err_i, .overload_i, .totalizer_overflow_i,
    .memory_overflow_i, .alarm_hit_i, .alarm_queue_busy_i, .alarm_queue_overflow_i, .scanning_i, .scan_start_i,
    .front_panel_change_i, .readings_stored_i, .status_byte_o, .alarm_summary_o, .err_push_o, .err_bits_o);

  host_model host_model_inst (.core_clk_i, .cmd_ready_i(cmd_ready_o), .resp_valid_i(resp_valid_o),
    .resp_data_i(resp_data_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i));

  function automatic logic [15:0] ev_exp(logic [16:0] x);
    ev_exp = {10'h000, x[16], x[15], x[14], |x[13:11], 2'b00};
  endfunction

  function automatic logic [15:0] qu_exp(logic [16:0] x);
    qu_exp = {3'h0, x[5], x[6], x[10], x[9], 7'h00, x[8], x[7]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic [4:0] c);
    host_model_inst.send(c, 16'h0000);
    chk("resp_valid", {15'h0000, host_model_inst.got}, 16'h0001);
  endtask

  task automatic pulse(input logic [16:0] x);
    pv <= x;
    @(posedge core_clk_i);
    #1;
    push = err_push_o;
    bits = err_bits_o;
    pv <= 17'h00000;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    #1000000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    {rst_b_i, commands_idle_i, alarm_queue_busy_i, scanning_i, scan_start_i, front_panel_change_i} = 6'h00;
    pv = 17'h00000;
    readings_stored_i = 16'h0000;
    nv_power_on_clear_i = 1'b1;
    nv_event_mask_i = 8'hFF;
    void'($urandom(95510));
    do_reset();
    chk("ev_mask_pwr", {8'h00, event_mask_o}, 16'h0000);
    chk("ready", {15'h0000, cmd_ready_o}, 16'h0001);
    for (int g = 0; g < 4; g++)
    begin
      rd(5'(`CMD_EVENT_MASK_READ + g));
      chk("mask_pwr", host_model_inst.resp, 16'h0000);
    end
    rd(`CMD_EVENT_LATCH_READ);
    chk("ev_power", host_model_inst.resp, 16'h0080);
    rd(`CMD_EVENT_LATCH_READ);
    chk("ev_reread", host_model_inst.resp, 16'h0000);
    for (int i = 0; i < 24; i++)
    begin
      m = (i == 1) ? 8'h00 : 8'($urandom);
      v = (i == 0) ? 17'h1F800 : {6'($urandom_range(63, 1)), 11'h000};
      host_model_inst.send(`CMD_EVENT_MASK_WRITE, {8'h00, m});
      chk("ev_mask", {8'h00, event_mask_o}, {8'h00, m & 8'hBD});
      pulse(v);
      chk("push", {15'h0000, push}, 16'h0001);
      chk("err_bits", {12'h000, bits}, {12'h000, v[16:14], |v[13:11]});
      chk("sb_event", {15'h0000, status_byte_o[5]}, {15'h0000, |(ev_exp(v) & {8'h00, m})});
      rd(`CMD_EVENT_LATCH_READ);
      chk("ev_latch", host_model_inst.resp, ev_exp(v));
    end
    for (int i = 0; i < 8; i++)
    begin
      v = {6'h00, 4'($urandom_range(15, 1)), 2'($urandom), 5'h00};
      qm = 16'($urandom);
      host_model_inst.send(`CMD_QUALITY_MASK_WRITE, qm);
      pulse(v);
      chk("ovl_push", {15'h0000, push}, 16'h0000);
      chk("sb_quality", {15'h0000, status_byte_o[3]}, {15'h0000, |(qu_exp(v) & qm)});
      rd(`CMD_QUALITY_LATCH_READ);
      chk("qu_latch", host_model_inst.resp, qu_exp(v));
      rd(`CMD_QUALITY_LATCH_READ);
      chk("qu_reread", host_model_inst.resp, 16'h0000);
      rd(`CMD_EVENT_LATCH_READ);
      chk("ovl_event", host_model_inst.resp, 16'h0008);
    end
    host_model_inst.send(`CMD_COMPLETION_MARKER, 16'h0000);
    repeat (3) @(posedge core_clk_i);
    rd(`CMD_EVENT_LATCH_READ);
    chk("opc_early", host_model_inst.resp, 16'h0000);
    commands_idle_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    commands_idle_i <= 1'b0;
    rd(`CMD_EVENT_LATCH_READ);
    chk("opc_done", host_model_inst.resp, 16'h0001);
    host_model_inst.send(5'h1F, 16'h0000);
    rd(`CMD_EVENT_LATCH_READ);
    chk("unknown", host_model_inst.resp, 16'h0020);
    v = {12'h000, 4'($urandom_range(15, 1)), 1'b1};
    host_model_inst.send(`CMD_ALARM_MASK_WRITE, 16'h0021);
    alarm_queue_busy_i <= 1'b1;
    pulse(v);
    chk("al_summary", {15'h0000, alarm_summary_o}, 16'h0001);
    rd(`CMD_ALARM_COND_READ);
    chk("al_cond", host_model_inst.resp, 16'h0010);
    rd(`CMD_ALARM_LATCH_READ);
    chk("al_latch", host_model_inst.resp, {10'h000, 2'b11, v[4:1]});
    rd(`CMD_ALARM_LATCH_READ);
    chk("al_reread", host_model_inst.resp, 16'h0000);
    pulse(17'h1F8FF);
    host_model_inst.send(`CMD_CLEAR_STATUS, 16'h0000);
    for (int g = 0; g < 4; g++)
    begin
      rd(5'(`CMD_EVENT_LATCH_READ + g));
      chk("cls", host_model_inst.resp, 16'h0000);
    end
    scanning_i <= 1'b1;
    readings_stored_i <= 16'h0005;
    front_panel_change_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rd(`CMD_OPER_COND_READ);
    chk("op_cond", host_model_inst.resp, 16'h0310);
    rd(`CMD_OPER_LATCH_READ);
    chk("op_latch", host_model_inst.resp, 16'h0310);
    front_panel_change_i <= 1'b0;
    scan_start_i <= 1'b1;
    @(posedge core_clk_i);
    scan_start_i <= 1'b0;
    @(posedge core_clk_i);
    rd(`CMD_OPER_COND_READ);
    chk("op_scan", host_model_inst.resp, 16'h0210);
    rd(`CMD_OPER_LATCH_READ);
    chk("op_reread", host_model_inst.resp, 16'h0000);
    host_model_inst.send(`CMD_THRESHOLD_WRITE, 16'h0000);
    rd(`CMD_THRESHOLD_READ);
    chk("thresh", host_model_inst.resp, `THRESHOLD_RESET);
    for (int g = 0; g < 3; g++)
    begin
      host_model_inst.send(5'(`CMD_QUALITY_MASK_WRITE + g), 16'hFFFF);
      rd(5'(`CMD_QUALITY_MASK_READ + g));
      chk("mask_full", host_model_inst.resp, (g == 0) ? 16'h1E03 : (g == 1) ? 16'h003F : 16'h0310);
    end
    m = event_mask_o;
    host_model_inst.send(`CMD_STATUS_PRESET, 16'h0000);
    chk("preset_ev", {8'h00, event_mask_o}, {8'h00, m});
    for (int g = 0; g < 3; g++)
    begin
      rd(5'(`CMD_QUALITY_MASK_READ + g));
      chk("preset", host_model_inst.resp, 16'h0000);
      host_model_inst.send(5'(`CMD_QUALITY_MASK_WRITE + g), 16'hFFFF);
    end
    host_model_inst.send(`CMD_POWER_ON_CLEAR_WR, 16'h0000);
    chk("pwr_flag", {15'h0000, power_on_clear_o}, 16'h0000);
    nv_power_on_clear_i <= 1'b0;
    nv_event_mask_i <= 8'h5A;
    do_reset();
    chk("ev_mask_keep", {8'h00, event_mask_o}, 16'h0018);
    for (int g = 0; g < 3; g++)
    begin
      rd(5'(`CMD_QUALITY_MASK_READ + g));
      chk("mask_pwr2", host_model_inst.resp, 16'h0000);
    end
    close_out();
  end
endmodule

bind status_event_register_groups status_props status_props_inst (.core_clk_i, .rst_b_i, .cmd_valid_i,
  .cmd_code_i, .cmd_data_i, .cmd_ready_o, .resp_valid_o, .event_mask_o, .commands_idle_i, .read_empty_err_i,
  .unread_query_err_i, .buffers_full_err_i, .selftest_err_i, .exec_err_i, .syntax_err_i, .overload_i,
  .totalizer_overflow_i, .memory_overflow_i, .status_byte_o, .err_push_o, .err_bits_o);

`default_nettype wire
